// file: design/bsl_defines.vh
// Constants for the boot stream block loader
// Behaviour
// - Header word one: type tag in bits 15..0, upper bits ignored.
// - Header word two: start address in bits 47..16, word count in 15..0.
// - Body words follow only for init blocks; zero blocks have no body.
// - Init blocks store body words at address; zero blocks write zeros.
// - Data-memory tags decode to space, width and zero/init kind.
// - Program-memory tags decode likewise, each with a unique code.
// - Tag zero is the final initialization block, ending block processing.
// - Final init overwrites loader region, clears interrupts, restores defaults.
// - Before each block the selected boot port is enabled for the header.
// - Boot port vector holds a return-from-interrupt, resuming at reset vector.
// - After boot, execution starts at the second reset-vector location.
// - First reset-vector location is 0x40004 and is not executed at boot.
// - Booting from any external source places the vector table internally.
// - In no-boot mode, select bit 1 picks internal, 0 external table.
// - Select bit resets to 0 and only matters in no-boot mode.
// - No-boot starts fetch at 0x800004 with DMA registers at defaults.
`ifndef BSL_DEFINES_VH
`define BSL_DEFINES_VH

`define BSL_TAG_FINAL      16'h0000
`define BSL_TAG_ZERO_DM16  16'h0001
`define BSL_TAG_ZERO_DM32  16'h0002
`define BSL_TAG_ZERO_DM40  16'h0003
`define BSL_TAG_INIT_DM16  16'h0004
`define BSL_TAG_INIT_DM32  16'h0005
`define BSL_TAG_ZERO_PM16  16'h0007
`define BSL_TAG_ZERO_PM32  16'h0008
`define BSL_TAG_ZERO_PM40  16'h0009
`define BSL_TAG_ZERO_PM48  16'h000a
`define BSL_TAG_INIT_PM16  16'h000b
`define BSL_TAG_INIT_PM32  16'h000c
`define BSL_TAG_INIT_PM48  16'h000e
`define BSL_TAG_ZERO_DM64  16'h000f
`define BSL_TAG_INIT_DM64  16'h0010
`define BSL_TAG_ZERO_PM64  16'h0011
`define BSL_TAG_INIT_PM64  16'h0012

`define BSL_TAG_LSB        0
`define BSL_TAG_MSB        15
`define BSL_CNT_LSB        0
`define BSL_CNT_MSB        15
`define BSL_ADDR_LSB       16
`define BSL_ADDR_MSB       47

`define BSL_WIDTH_16       3'h0
`define BSL_WIDTH_32       3'h1
`define BSL_WIDTH_40       3'h2
`define BSL_WIDTH_48       3'h3
`define BSL_WIDTH_64       3'h4

`define BSL_RESET_VEC0     32'h00040004
`define BSL_RESET_VEC1     32'h00040005
`define BSL_NOBOOT_VEC     32'h00800004

`define BSL_MODE_NOBOOT    2'h0
`define BSL_MODE_EXT       2'h1
`define BSL_MODE_LINK      2'h2

`define BSL_REG_STATUS     4'h0
`define BSL_REG_SYSCFG     4'h1
`define BSL_REG_DMACTL     4'h2
`define BSL_REG_LINKCTL    4'h3
`define BSL_REG_START      4'h4
`define BSL_REG_LASTTAG    4'h5
`define BSL_REG_BLOCKS     4'h6

`define BSL_SYSCFG_IVT_BIT 0
`define BSL_SYSCFG_RST     32'h00000000
`define BSL_DMACTL_RST     32'h00000000
`define BSL_LINKCTL_RST    32'h00000000

`define BSL_OVL_WORDS      16'h0100

`endif

// file: design/bsl_write_reg.v
// Write-side holding register for memory writes, output from flip-flops
`timescale 1ns/1ps
`default_nettype none
module bsl_write_reg (
  input  wire        ref_clk,
  input  wire        reset,
  input  wire        wr_in,
  input  wire        pm_in,
  input  wire [31:0] addr_in,
  input  wire [63:0] data_in,
  output reg         mem_wr,
  output reg         mem_pm,
  output reg  [31:0] mem_addr,
  output reg  [63:0] mem_wdata
);
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mem_wr    <= 1'b0;
      mem_pm    <= 1'b0;
      mem_addr  <= 32'h0;
      mem_wdata <= 64'h0;
    end else begin
      mem_wr <= wr_in;
      if (wr_in) begin
        mem_pm    <= pm_in;
        mem_addr  <= addr_in;
        mem_wdata <= data_in;
      end
    end
  end
endmodule
`default_nettype wire

// file: design/bsl_loader.v
// Boot stream block loader: header parsing, store, zero fill, final init
`timescale 1ns/1ps
`default_nettype none
`include "bsl_defines.vh"
module bsl_loader (
  input  wire        ref_clk,
  input  wire        reset,
  input  wire [1:0]  boot_mode,
  input  wire        stream_valid,
  input  wire [47:0] stream_word,
  output wire        stream_ready,
  output reg         ext_port_enable,
  output reg         link_port_enable,
  output wire        mem_wr,
  output wire        mem_pm,
  output wire [31:0] mem_addr,
  output wire [63:0] mem_wdata,
  output reg         irq_clear,
  output reg         boot_done,
  output reg         rti_at_port_vector,
  output reg         internal_vector_table,
  output reg         fetch_start,
  output reg  [31:0] fetch_addr,
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata
);

  // ****************************************
  // Tag decode
  // ****************************************
  // Returns {known, pm, init, width[2:0]}
  function [5:0] tag_decode;
    input [15:0] tag;
    begin
      case (tag)
        `BSL_TAG_ZERO_DM16: tag_decode = {3'b100, `BSL_WIDTH_16};
        `BSL_TAG_ZERO_DM32: tag_decode = {3'b100, `BSL_WIDTH_32};
        `BSL_TAG_ZERO_DM40: tag_decode = {3'b100, `BSL_WIDTH_40};
        `BSL_TAG_INIT_DM16: tag_decode = {3'b101, `BSL_WIDTH_16};
        `BSL_TAG_INIT_DM32: tag_decode = {3'b101, `BSL_WIDTH_32};
        `BSL_TAG_ZERO_DM64: tag_decode = {3'b100, `BSL_WIDTH_64};
        `BSL_TAG_INIT_DM64: tag_decode = {3'b101, `BSL_WIDTH_64};
        `BSL_TAG_ZERO_PM16: tag_decode = {3'b110, `BSL_WIDTH_16};
        `BSL_TAG_ZERO_PM32: tag_decode = {3'b110, `BSL_WIDTH_32};
        `BSL_TAG_ZERO_PM40: tag_decode = {3'b110, `BSL_WIDTH_40};
        `BSL_TAG_ZERO_PM48: tag_decode = {3'b110, `BSL_WIDTH_48};
        `BSL_TAG_INIT_PM16: tag_decode = {3'b111, `BSL_WIDTH_16};
        `BSL_TAG_INIT_PM32: tag_decode = {3'b111, `BSL_WIDTH_32};
        `BSL_TAG_INIT_PM48: tag_decode = {3'b111, `BSL_WIDTH_48};
        `BSL_TAG_ZERO_PM64: tag_decode = {3'b110, `BSL_WIDTH_64};
        `BSL_TAG_INIT_PM64: tag_decode = {3'b111, `BSL_WIDTH_64};
        default:            tag_decode = 6'h00;
      endcase
    end
  endfunction

  // ****************************************
  // Address and count stepping
  // ****************************************
  // Shared by body store, zero fill and overlay
  function [31:0] addr_step;
    input [31:0] a;
    begin
      addr_step = a + 32'h1;
    end
  endfunction

  function [15:0] count_step;
    input [15:0] c;
    begin
      count_step = c - 16'h1;
    end
  endfunction

  // True while the last word of a block is handled
  function last_word;
    input [15:0] c;
    begin
      last_word = (c == 16'h1);
    end
  endfunction

  // ****************************************
  // State machine
  // ****************************************
  localparam [3:0] ST_IDLE   = 4'h0;
  localparam [3:0] ST_HDR1   = 4'h1;
  localparam [3:0] ST_HDR2   = 4'h2;
  localparam [3:0] ST_BODY   = 4'h3;
  localparam [3:0] ST_ZERO   = 4'h4;
  localparam [3:0] ST_FINAL  = 4'h5;
  localparam [3:0] ST_RESTOR = 4'h6;
  localparam [3:0] ST_DONE   = 4'h7;
  localparam [3:0] ST_NOBOOT = 4'h8;
  localparam [3:0] ST_ERROR  = 4'h9;

  reg [3:0]  state_r;
  reg [15:0] tag_r;
  reg [31:0] addr_r;
  reg [15:0] count_r;
  reg [31:0] sys_cfg_r;
  reg [31:0] dma_ctl_r;
  reg [31:0] link_ctl_r;
  reg [15:0] blocks_r;
  reg        wr_nxt;
  reg [63:0] data_nxt;
  reg        bad_tag_r;

  wire       booting   = (boot_mode != `BSL_MODE_NOBOOT);
  wire [5:0] dec_cur   = tag_decode(tag_r);
  wire       take_word = stream_valid & stream_ready;

  assign stream_ready = (state_r == ST_HDR1) | (state_r == ST_HDR2) |
                        (state_r == ST_BODY) | (state_r == ST_FINAL);

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_r    <= ST_IDLE;
      tag_r      <= 16'h0;
      addr_r     <= 32'h0;
      count_r    <= 16'h0;
      blocks_r   <= 16'h0;
      bad_tag_r  <= 1'b0;
      boot_done  <= 1'b0;
      irq_clear  <= 1'b0;
      fetch_start <= 1'b0;
      fetch_addr <= 32'h0;
      ext_port_enable  <= 1'b0;
      link_port_enable <= 1'b0;
      rti_at_port_vector <= 1'b0;
    end else begin
      irq_clear   <= 1'b0;
      fetch_start <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (booting) begin
            // Port turns on in the same cycle that ready first rises for a header
            ext_port_enable    <= (boot_mode == `BSL_MODE_EXT);
            link_port_enable   <= (boot_mode == `BSL_MODE_LINK);
            rti_at_port_vector <= 1'b1;
            state_r <= ST_HDR1;
          end else begin
            state_r <= ST_NOBOOT;
          end
        end
        ST_HDR1: begin
          ext_port_enable  <= (boot_mode == `BSL_MODE_EXT);
          link_port_enable <= (boot_mode == `BSL_MODE_LINK);
          if (take_word) begin
            tag_r   <= stream_word[`BSL_TAG_MSB:`BSL_TAG_LSB];
            state_r <= ST_HDR2;
          end
        end
        ST_HDR2: begin
          if (take_word) begin
            addr_r  <= stream_word[`BSL_ADDR_MSB:`BSL_ADDR_LSB];
            count_r <= stream_word[`BSL_CNT_MSB:`BSL_CNT_LSB];
            blocks_r <= blocks_r + 16'h1;
            if (tag_r == `BSL_TAG_FINAL) begin
              count_r <= `BSL_OVL_WORDS;
              addr_r  <= `BSL_RESET_VEC0;
              state_r <= ST_FINAL;
            end else if (!dec_cur[5]) begin
              bad_tag_r <= 1'b1;
              state_r   <= ST_ERROR;
            end else if (stream_word[`BSL_CNT_MSB:`BSL_CNT_LSB] == 16'h0) begin
              state_r <= ST_HDR1;
            end else if (dec_cur[3]) begin
              state_r <= ST_BODY;
            end else begin
              state_r <= ST_ZERO;
            end
          end
        end
        ST_BODY, ST_ZERO: begin
          // Header is re-read only after the last word lands
          if (state_r == ST_ZERO || take_word) begin
            addr_r  <= addr_step(addr_r);
            count_r <= count_step(count_r);
            if (last_word(count_r))
              state_r <= ST_HDR1;
          end
        end
        ST_FINAL: begin
          // Overlay over the loader region itself
          if (take_word) begin
            addr_r  <= addr_step(addr_r);
            count_r <= count_step(count_r);
            if (last_word(count_r)) begin
              irq_clear <= 1'b1;
              state_r   <= ST_RESTOR;
            end
          end
        end
        ST_RESTOR: begin
          ext_port_enable    <= 1'b0;
          link_port_enable   <= 1'b0;
          rti_at_port_vector <= 1'b0;
          boot_done   <= 1'b1;
          fetch_start <= 1'b1;
          fetch_addr  <= `BSL_RESET_VEC1;
          state_r     <= ST_DONE;
        end
        ST_NOBOOT: begin
          boot_done   <= 1'b1;
          fetch_start <= 1'b1;
          fetch_addr  <= `BSL_NOBOOT_VEC;
          state_r     <= ST_DONE;
        end
        ST_DONE:  state_r <= ST_DONE;
        ST_ERROR: state_r <= ST_ERROR;
        default:  state_r <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Memory write path
  // ****************************************
  always @* begin
    wr_nxt   = 1'b0;
    data_nxt = 64'h0;
    case (state_r)
      ST_BODY: begin
        wr_nxt   = take_word;
        data_nxt = {16'h0, stream_word};
      end
      ST_ZERO: begin
        wr_nxt   = 1'b1;
        data_nxt = 64'h0;
      end
      ST_FINAL: begin
        wr_nxt   = take_word;
        data_nxt = {16'h0, stream_word};
      end
      default: begin
        wr_nxt   = 1'b0;
        data_nxt = 64'h0;
      end
    endcase
  end

  bsl_write_reg u_wreg (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .wr_in     (wr_nxt),
    .pm_in     (state_r == ST_FINAL ? 1'b1 : dec_cur[4]),
    .addr_in   (addr_r),
    .data_in   (data_nxt),
    .mem_wr    (mem_wr),
    .mem_pm    (mem_pm),
    .mem_addr  (mem_addr),
    .mem_wdata (mem_wdata)
  );

  // ****************************************
  // Configuration registers and vector table
  // ****************************************
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sys_cfg_r  <= `BSL_SYSCFG_RST;
      dma_ctl_r  <= `BSL_DMACTL_RST;
      link_ctl_r <= `BSL_LINKCTL_RST;
    end else if (state_r == ST_RESTOR || state_r == ST_NOBOOT) begin
      sys_cfg_r  <= `BSL_SYSCFG_RST;
      dma_ctl_r  <= `BSL_DMACTL_RST;
      link_ctl_r <= `BSL_LINKCTL_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `BSL_REG_SYSCFG:  sys_cfg_r  <= reg_wdata;
        `BSL_REG_DMACTL:  dma_ctl_r  <= reg_wdata;
        `BSL_REG_LINKCTL: link_ctl_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Select bit only counts when nothing was booted
  always @(posedge ref_clk or posedge reset) begin
    if (reset)
      internal_vector_table <= 1'b0;
    else if (booting)
      internal_vector_table <= 1'b1;
    else
      internal_vector_table <= sys_cfg_r[`BSL_SYSCFG_IVT_BIT];
  end

  // ****************************************
  // Register read port
  // ****************************************
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        `BSL_REG_STATUS:  reg_rdata <= {22'h0, bad_tag_r, boot_done,
                                        internal_vector_table, 3'h0,
                                        state_r};
        `BSL_REG_SYSCFG:  reg_rdata <= sys_cfg_r;
        `BSL_REG_DMACTL:  reg_rdata <= dma_ctl_r;
        `BSL_REG_LINKCTL: reg_rdata <= link_ctl_r;
        `BSL_REG_START:   reg_rdata <= fetch_addr;
        `BSL_REG_LASTTAG: reg_rdata <= {16'h0, tag_r};
        `BSL_REG_BLOCKS:  reg_rdata <= {16'h0, blocks_r};
        default:          reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

endmodule
`default_nettype wire

// file: testbench/bsl_loader_sva.sv
// Port checker for the boot stream block loader
`timescale 1ns/1ps
`default_nettype none
`include "bsl_defines.vh"
module bsl_loader_sva (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic [1:0]  boot_mode,
  input wire logic        stream_valid,
  input wire logic        stream_ready,
  input wire logic        ext_port_enable,
  input wire logic        link_port_enable,
  input wire logic        mem_wr,
  input wire logic [63:0] mem_wdata,
  input wire logic        irq_clear,
  input wire logic        boot_done,
  input wire logic        internal_vector_table,
  input wire logic        fetch_start,
  input wire logic [31:0] fetch_addr,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr
);
  // ********************
  // Properties
  // ********************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_boot_fetch;
    ##[1:8] (fetch_start && fetch_addr == `BSL_RESET_VEC1);
  endsequence
  sequence s_noboot_fetch;
    ##[0:4] (fetch_start && fetch_addr == `BSL_NOBOOT_VEC);
  endsequence
  property p_port_en;
    stream_ready |-> (boot_mode == `BSL_MODE_LINK) ?
      (link_port_enable && !ext_port_enable) :
      (ext_port_enable && !link_port_enable);
  endproperty
  a_port_en: assert property (p_port_en) else $error("wrong boot port");
  // A write with no word taken just before it can only be zero fill
  property p_zero_fill;
    mem_wr && !$past(stream_valid && stream_ready) |-> mem_wdata == 64'h0;
  endproperty
  a_zero_fill: assert property (p_zero_fill) else $error("fill not zero");
  property p_final_seq;
    irq_clear |-> s_boot_fetch;
  endproperty
  a_final_seq: assert property (p_final_seq) else $error("no user start");
  property p_noboot;
    $fell(reset) && boot_mode == `BSL_MODE_NOBOOT |-> s_noboot_fetch;
  endproperty
  a_noboot: assert property (p_noboot) else $error("no-boot start");
  property p_boot_ivt;
    boot_done && boot_mode != `BSL_MODE_NOBOOT |-> internal_vector_table;
  endproperty
  a_boot_ivt: assert property (p_boot_ivt) else $error("table not int");
  property p_ivt_sel;
    boot_mode == `BSL_MODE_NOBOOT && reg_wr && reg_addr == `BSL_REG_SYSCFG
      |-> ##2 internal_vector_table == $past(reg_wdata[0], 2);
  endproperty
  a_ivt_sel: assert property (p_ivt_sel) else $error("table select");
  property p_fetch_done;
    fetch_start && boot_mode != `BSL_MODE_NOBOOT |-> ##[0:1] boot_done;
  endproperty
  a_fetch_done: assert property (p_fetch_done) else $error("done late");
  property p_done_quiet;
    boot_done |-> !mem_wr && !stream_ready;
  endproperty
  a_done_quiet: assert property (p_done_quiet) else $error("busy at end");
endmodule
bind bsl_loader bsl_loader_sva i_sva (
  .ref_clk, .reset, .boot_mode, .stream_valid, .stream_ready,
  .ext_port_enable, .link_port_enable, .mem_wr, .mem_wdata, .irq_clear,
  .boot_done, .internal_vector_table, .fetch_start, .fetch_addr,
  .reg_addr, .reg_wdata, .reg_wr
);
`default_nettype wire

// file: testbench/bsl_src_model.sv
// Boot source model feeding 48-bit stream words in order
`timescale 1ns/1ps
`default_nettype none
module bsl_src_model (
  input  wire logic        ref_clk,
  input  wire logic        slow,
  input  wire logic        stream_ready,
  output var  logic        stream_valid,
  output var  logic [47:0] stream_word
);
  logic [47:0] q[$];
  logic        gap;
  initial begin
    stream_valid = 1'b0;
    stream_word  = 48'h0;
    gap          = 1'b0;
  end
  task automatic push(input logic [47:0] w);
    q.push_back(w);
  endtask
  // Offered word holds until taken; idle line shows no stale word
  always @(posedge ref_clk) begin
    if (stream_valid && stream_ready)
      void'(q.pop_front());
    gap <= slow & ~gap;
    if (!(stream_valid && !stream_ready)) begin
      if (q.size() != 0 && !(slow && gap)) begin
        stream_valid <= 1'b1;
        stream_word  <= q[0];
      end else begin
        stream_valid <= 1'b0;
        stream_word  <= ~stream_word;
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the boot stream block loader
`timescale 1ns/1ps
`default_nettype none
`include "bsl_defines.vh"
module tb;
  logic        ref_clk, reset, slow, reg_wr, reg_rd, rd_d;
  logic [1:0]  boot_mode;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, seed;
  wire         stream_valid, stream_ready, mem_wr, mem_pm, irq_clear;
  wire         boot_done, rti_at_port_vector, internal_vector_table;
  wire         fetch_start;
  wire  [47:0] stream_word;
  wire  [31:0] mem_addr, fetch_addr, reg_rdata;
  wire  [63:0] mem_wdata;
  int          n_fail, checks, n_irq;
  logic [96:0] exp_q[$];
  logic [31:0] fq[$], rq[$];
  bsl_loader i_dut (
    .ref_clk, .reset, .boot_mode, .stream_valid, .stream_word,
    .stream_ready, .ext_port_enable(), .link_port_enable(), .mem_wr,
    .mem_pm, .mem_addr, .mem_wdata, .irq_clear, .boot_done,
    .rti_at_port_vector, .internal_vector_table, .fetch_start,
    .fetch_addr, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata
  );
  bsl_src_model i_src (
    .ref_clk, .slow, .stream_ready, .stream_valid, .stream_word
  );
  // ********************
  // Helpers
  // ********************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [96:0] got, exp, input string m);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    rq.push_back(e);
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
  endtask
  // Zero blocks carry no body; expected memory writes queued alongside
  task automatic blk(input logic [15:0] t, c, input logic [31:0] a,
                     input logic body, pm);
    logic [47:0] w;
    i_src.push({rnd(), t});
    i_src.push({a, c});
    for (int i = 0; i < c; i++) begin
      w = body ? 48'({rnd(), rnd()}) : 48'h0;
      if (body) i_src.push(w);
      exp_q.push_back({pm, a + 32'(i), 16'h0, w});
    end
  endtask
  always @(posedge ref_clk) begin
    rd_d <= reg_rd;
    if (rd_d) chk(reg_rdata, rq.pop_front(), "rdata");
    if (mem_wr === 1'b1) chk({mem_pm, mem_addr, mem_wdata}, exp_q.pop_front(), "mem");
    if (fetch_start === 1'b1) chk(fetch_addr, fq.pop_front(), "fetch");
    if (irq_clear === 1'b1) n_irq++;
  end
  task automatic run_boot(input logic [1:0] m);
    @(posedge ref_clk);
    reset     <= 1'b1;
    boot_mode <= m;
    slow      <= m[1];
    for (int t = 1; t < 19; t++) begin
      if (t != 6 && t != 13) begin
        blk(16'(t), (t == 1) ? 16'h0 : 16'(1 + rnd() % 3), rnd(),
            t inside {4, 5, 11, 12, 14, 16, 18},
            (t > 6 && t < 15) || t > 16);
      end
    end
    blk(16'h0, 16'h0100, 32'h00040004, 1'b1, 1'b1);
    fq.push_back(32'h00040005);
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (6) @(posedge ref_clk);
    #1 chk(rti_at_port_vector, 1, "rti");
    for (int a = 1; a < 4; a++) wr(4'(a), rnd());
    for (int i = 0; i < 4000 && boot_done !== 1'b1; i++) @(posedge ref_clk);
    #1 chk(internal_vector_table, 1, "ivt boot");
    chk(n_irq, m, "irq");
    chk(exp_q.size(), 0, "writes");
    for (int a = 1; a < 4; a++) rd(4'(a), 32'h0);
  endtask
  task automatic end_of_test();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ********************
  // Sequence
  // ********************
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    #(50 * 20000);
    n_fail++;
    end_of_test();
  end
  initial begin
    {reset, boot_mode, slow, reg_wr, reg_rd, rd_d} = 7'h48;
    {reg_addr, reg_wdata, n_fail, checks, n_irq} = '0;
    seed = 32'hfb8c;
    for (int m = 1; m < 3; m++) run_boot(2'(m));
    @(posedge ref_clk);
    reset     <= 1'b1;
    boot_mode <= `BSL_MODE_NOBOOT;
    fq.push_back(32'h00800004);
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    #1 chk(internal_vector_table, 0, "ivt reset");
    wr(`BSL_REG_SYSCFG, 32'h1);
    repeat (3) @(posedge ref_clk);
    #1 chk(internal_vector_table, 1, "ivt int");
    rd(`BSL_REG_SYSCFG, 32'h1);
    wr(`BSL_REG_SYSCFG, 32'h0);
    repeat (3) @(posedge ref_clk);
    #1 chk(internal_vector_table, 0, "ivt ext");
    rd(4'hf, 32'h0);
    repeat (3) @(posedge ref_clk);
    chk(fq.size(), 0, "fetch count");
    end_of_test();
  end
endmodule
`default_nettype wire
